// ==== src/cth_top.v ====
// CAN transmit message handler, acceptance filter and register port
//
// Functional notes
// - Three-entry pipeline rescanned for best pending
// - Higher-priority request inserted ahead of queued entries
// - Failed message stays pending, later rescan reinserts
// - Select bit zero: dedicated buffers plus FIFO
// - Add request; completion sets flag; occurred bit too, except buffers 0-3 in an add request cycle
// - FIFO-empty flag on last FIFO completion
// - Configs 100/101/110 mark matches high priority
// - Priority flag only for filter-element acceptances
// - Non-match codes 00/01 still accept frame
// - Config 001 to FIFO 0, 010 FIFO 1
// - Type 10: classic value and mask filter
// - Activity field reads 10 while receiving
// - Dominant third intermission bit is SoF
// - Arbitrate, load output buffer, then request
// - Shift register holds ID and DLC
// - Acknowledged transmission logs ID in event FIFO
`timescale 1ns/100ps
`include "cth_map.vh"
module cth_top (
    input wire i_clock, // System clock, 100 MHz
    input wire i_sys_rst, // Synchronous reset, active high
    input wire [5:0] i_addr, // Register byte address
    input wire [31:0] i_wdata, // Register write data
    input wire i_wr, // Write strobe
    input wire i_rd, // Read strobe
    output reg [31:0] o_rdata, // Read data, cycle after strobe
    output reg o_irq, // Level interrupt
    output reg o_pe_req, // Transmit request to protocol engine
    output reg [10:0] o_pe_id, // Shift register identifier
    output reg [3:0] o_pe_dlc, // Shift register length code
    output reg o_pe_arb_start, // Arbitration starts this bit
    input wire i_pe_done, // Acknowledged transmission, pulse
    input wire i_pe_fail, // Lost arbitration or error, pulse
    input wire i_bit_tick, // One pulse per bit time
    input wire i_ifs3_dominant, // Third intermission bit dominant
    input wire i_pe_receiving, // Engine acts as receiver
    input wire i_pe_transmitting, // Engine acts as transmitter
    input wire i_pe_idle, // Engine bus idle
    input wire i_rx_valid, // Received frame valid, pulse
    input wire i_rx_ext, // Received frame has extended ID
    input wire [28:0] i_rx_id, // Received identifier
    output reg o_rx_store, // Frame accepted, pulse
    output reg o_rx_fifo1, // Accepted frame goes to FIFO 1
    output reg o_rx_high_prio // Accepted as high priority
);

    // ********************
    // State and storage
    // ********************
    localparam ST_IDLE = 2'h0; // No message in output buffer
    localparam ST_LOAD = 2'h1; // Output buffer loaded
    localparam ST_BUSY = 2'h2; // Request raised to engine

    reg [1:0] tx_state; // Handler state
    reg fifo_queue_select; // 0: FIFO order kept
    reg [10:0] msg_id [0:7]; // Message RAM identifiers
    reg [3:0] msg_dlc [0:7]; // Message RAM length codes
    reg [7:0] tx_request_pending; // Pending per buffer
    reg [7:0] tx_occurred_bits; // Completed per buffer
    reg [1:0] fifo_get; // Oldest FIFO slot
    reg [1:0] fifo_put; // Next free FIFO slot
    reg [2:0] pipe_v; // Pipeline position valid
    reg [8:0] pipe_idx; // Pipeline buffer numbers
    reg [2:0] sh_idx; // Buffer in shift register
    reg sof_seen; // SoF taken at intermission
    reg [`CTH_NIRQ-1:0] irq_status; // Sticky events
    reg [`CTH_NIRQ-1:0] irq_mask; // Interrupt enables
    reg [1:0] protocol_activity_state; // Engine activity
    reg [31:0] std_flt; // Standard filter element
    reg [31:0] ext_flt_a; // Extended element, word A
    reg [31:0] ext_flt_b; // Extended element, word B
    reg [3:0] glb_flt; // Global non-match handling
    reg [10:0] evt_id [0:3]; // Transmit event FIFO
    reg [1:0] evt_wp; // Event write pointer
    reg [1:0] evt_rp; // Event read pointer
    reg [2:0] evt_cnt; // Event fill level

    wire busy = (tx_state != ST_IDLE); // Position 1 locked
    wire wr_req = i_wr && (i_addr == `CTH_A_ADDREQ);
    wire wr_put = i_wr && (i_addr == `CTH_A_FIFOPUT);
    wire put_ok = !tx_request_pending[{1'b1, fifo_put}];
    wire tx_ok = (tx_state == ST_BUSY) && i_pe_done;
    wire tx_bad = (tx_state == ST_BUSY) && i_pe_fail;
    wire done_fifo = tx_ok && sh_idx[2];
    wire evt_pop = i_rd && (i_addr == `CTH_A_EVT) && (evt_cnt != 3'h0);
    wire evt_push = tx_ok && (evt_cnt != 3'h4);

    // ********************
    // Pipeline scan
    // ********************
    reg [2:0] next_pipe_v; // Scan result valid
    reg [8:0] next_pipe_idx; // Scan result buffers
    reg [7:0] avail; // Pending, not yet placed
    reg [1:0] fptr; // Next FIFO slot allowed
    reg found; // Candidate seen
    reg elig; // Candidate eligible
    reg [2:0] best; // Best candidate so far
    integer s;
    integer k;

    // Three successive minimum searches fill the pipeline, two while position 1 is locked
    always @* begin
        avail = tx_request_pending;
        fptr = fifo_get;
        next_pipe_v = 3'h0;
        next_pipe_idx = 9'h0;
        found = 1'b0;
        elig = 1'b0;
        best = 3'h0;
        for (s = 0; s < 3; s = s + 1) begin
            if (s == 0 && busy) begin
                // Transmitting entry keeps position 1
                next_pipe_v[0] = pipe_v[0];
                next_pipe_idx[2:0] = pipe_idx[2:0];
                avail[pipe_idx[2:0]] = 1'b0;
                if (pipe_idx[2]) begin
                    fptr = pipe_idx[1:0] + 2'h1;
                end
            end else begin
                found = 1'b0;
                best = 3'h0;
                for (k = 0; k < 8; k = k + 1) begin
                    // FIFO slots only in turn unless queue
                    elig = avail[k] && (k < `CTH_NDED ||
                        fifo_queue_select || k[1:0] == fptr);
                    // Lower identifier wins
                    if (elig && (!found || msg_id[k] < msg_id[best])) begin
                        found = 1'b1;
                        best = k[2:0];
                    end
                end
                next_pipe_v[s] = found;
                next_pipe_idx[s*3 +: 3] = best;
                if (found) begin
                    avail[best] = 1'b0;
                    if (best[2]) begin
                        fptr = best[1:0] + 2'h1;
                    end
                end
            end
        end
    end

    // Pipeline rescanned every cycle
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            pipe_v <= 3'h0;
            pipe_idx <= 9'h0;
        end else begin
            pipe_v <= next_pipe_v;
            pipe_idx <= next_pipe_idx;
        end
    end

    // ********************
    // Output buffer and engine handshake
    // ********************
    // Load buffer, then raise request one cycle later
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            tx_state <= ST_IDLE;
            o_pe_req <= 1'b0;
            o_pe_id <= 11'h0;
            o_pe_dlc <= 4'h0;
            sh_idx <= 3'h0;
        end else begin
            case (tx_state)
                ST_IDLE: begin
                    // Fresh scan: the registered one lags a completion
                    if (next_pipe_v[0]) begin
                        // Shift register gets ID and DLC
                        o_pe_id <= msg_id[next_pipe_idx[2:0]];
                        o_pe_dlc <= msg_dlc[next_pipe_idx[2:0]];
                        sh_idx <= next_pipe_idx[2:0];
                        tx_state <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    o_pe_req <= 1'b1;
                    tx_state <= ST_BUSY;
                end
                ST_BUSY: begin
                    if (i_pe_done || i_pe_fail) begin
                        // A failure leaves the buffer pending
                        o_pe_req <= 1'b0;
                        tx_state <= ST_IDLE;
                    end
                end
                default: begin
                    o_pe_req <= 1'b0;
                    tx_state <= ST_IDLE;
                end
            endcase
        end
    end

    // Dominant third intermission bit taken as SoF
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            sof_seen <= 1'b0;
            o_pe_arb_start <= 1'b0;
        end else begin
            o_pe_arb_start <= 1'b0;
            if (i_ifs3_dominant) begin
                sof_seen <= 1'b1;
            end else if (i_bit_tick && sof_seen) begin
                sof_seen <= 1'b0;
                o_pe_arb_start <= o_pe_req;
            end
        end
    end

    // ********************
    // Pending, occurred and FIFO pointers
    // ********************
    // Completion clears; a same-cycle add request rewrites bits 3:0 from their old values
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            tx_request_pending <= 8'h0;
            tx_occurred_bits <= 8'h0;
            fifo_get <= 2'h0;
            fifo_put <= 2'h0;
        end else begin
            if (tx_ok) begin
                tx_request_pending[sh_idx] <= 1'b0;
                tx_occurred_bits[sh_idx] <= 1'b1;
            end
            if (done_fifo) begin
                fifo_get <= sh_idx[1:0] + 2'h1;
            end
            if (wr_req) begin
                // New request clears old completion
                tx_request_pending[3:0] <=
                    tx_request_pending[3:0] | i_wdata[3:0];
                tx_occurred_bits[3:0] <=
                    tx_occurred_bits[3:0] & ~i_wdata[3:0];
            end
            if (wr_put && put_ok) begin
                tx_request_pending[{1'b1, fifo_put}] <= 1'b1;
                tx_occurred_bits[{1'b1, fifo_put}] <= 1'b0;
                fifo_put <= fifo_put + 2'h1;
            end
        end
    end

    // Message RAM written by software
    always @(posedge i_clock) begin
        if (i_wr && i_addr == `CTH_A_TXMSG) begin
            msg_id[i_wdata[`CTH_F_IDX]] <= i_wdata[`CTH_F_SID];
            msg_dlc[i_wdata[`CTH_F_IDX]] <= i_wdata[`CTH_F_DLC];
        end
        if (wr_put && put_ok) begin
            msg_id[{1'b1, fifo_put}] <= i_wdata[`CTH_F_SID];
            msg_dlc[{1'b1, fifo_put}] <= i_wdata[`CTH_F_DLC];
        end
    end

    // ********************
    // Transmit event FIFO
    // ********************
    // Identifier of acknowledged request logged
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            evt_wp <= 2'h0;
            evt_rp <= 2'h0;
            evt_cnt <= 3'h0;
        end else begin
            if (evt_push) begin
                evt_id[evt_wp] <= o_pe_id;
                evt_wp <= evt_wp + 2'h1;
            end
            if (evt_pop) begin
                evt_rp <= evt_rp + 2'h1;
            end
            if (evt_push && !evt_pop) begin
                evt_cnt <= evt_cnt + 3'h1;
            end else if (evt_pop && !evt_push) begin
                evt_cnt <= evt_cnt - 3'h1;
            end
        end
    end

    // ********************
    // Acceptance filter
    // ********************
    reg [2:0] f_cfg; // Element configuration
    reg [1:0] f_typ; // Element filter type
    reg [28:0] f_a; // First ID field
    reg [28:0] f_b; // Second ID field
    reg [1:0] f_anf; // Non-match handling
    reg f_hit; // Element matched
    reg nx_store; // Frame accepted
    reg nx_fifo1; // Target FIFO 1
    reg nx_hp; // High priority

    // Match one element, else global handling
    always @* begin
        f_cfg = i_rx_ext ? ext_flt_a[`CTH_F_CFG] : std_flt[`CTH_F_CFG];
        f_typ = i_rx_ext ? ext_flt_b[`CTH_F_ETYP] : std_flt[`CTH_F_STYP];
        f_a = i_rx_ext ? ext_flt_a[`CTH_F_EID] :
            {18'h0, std_flt[`CTH_F_SIDA]};
        f_b = i_rx_ext ? ext_flt_b[`CTH_F_EID] :
            {18'h0, std_flt[`CTH_F_SID]};
        f_anf = i_rx_ext ? glb_flt[`CTH_F_ANFE] : glb_flt[`CTH_F_ANFS];
        case (f_typ)
            `CTH_FT_RANGE: f_hit = (i_rx_id >= f_a) && (i_rx_id <= f_b);
            `CTH_FT_DUAL: f_hit = (i_rx_id == f_a) || (i_rx_id == f_b);
            // Mask bit zero excludes received ID bit
            `CTH_FT_CLASSIC: f_hit = ((i_rx_id ^ f_a) & f_b) == 29'h0;
            default: f_hit = 1'b0;
        endcase
        f_hit = f_hit && (f_cfg != `CTH_EC_OFF);
        if (f_hit) begin
            nx_store = (f_cfg != `CTH_EC_REJ);
            nx_fifo1 = (f_cfg == `CTH_EC_F1) || (f_cfg == `CTH_EC_PF1);
            nx_hp = f_cfg[2] && (f_cfg != `CTH_EC_BUF);
        end else begin
            nx_store = (f_anf == `CTH_ANF_F0) || (f_anf == `CTH_ANF_F1);
            nx_fifo1 = (f_anf == `CTH_ANF_F1);
            nx_hp = 1'b0;
        end
    end

    // Filter verdict registered as one-cycle pulse
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_rx_store <= 1'b0;
            o_rx_fifo1 <= 1'b0;
            o_rx_high_prio <= 1'b0;
        end else begin
            o_rx_store <= i_rx_valid && nx_store;
            o_rx_fifo1 <= i_rx_valid && nx_store && nx_fifo1;
            o_rx_high_prio <= i_rx_valid && nx_store && nx_hp;
        end
    end

    // ********************
    // Interrupts
    // ********************
    reg [`CTH_NIRQ-1:0] irq_set; // Events this cycle
    reg [`CTH_NIRQ-1:0] next_irq_status; // Status after update

    // Event set wins over write-one clear
    always @* begin
        irq_set = {`CTH_NIRQ{1'b0}};
        irq_set[`CTH_I_TC] = tx_ok;
        irq_set[`CTH_I_TFE] = done_fifo &&
            ((tx_request_pending & 8'hf0 & ~(8'h1 << sh_idx)) == 8'h0);
        irq_set[`CTH_I_HPM] = o_rx_high_prio;
        irq_set[`CTH_I_RXN] = o_rx_store;
        irq_set[`CTH_I_EVT] = evt_push;
        next_irq_status = irq_status;
        if (i_wr && i_addr == `CTH_A_IRQST) begin
            next_irq_status = irq_status & ~i_wdata[`CTH_NIRQ-1:0];
        end
        next_irq_status = next_irq_status | irq_set;
    end

    // Status, interrupt line and activity field
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            irq_status <= {`CTH_NIRQ{1'b0}};
            o_irq <= 1'b0;
            protocol_activity_state <= `CTH_ACT_SYNC;
        end else begin
            irq_status <= next_irq_status;
            o_irq <= |(next_irq_status & irq_mask);
            if (i_pe_receiving) begin
                protocol_activity_state <= `CTH_ACT_RX;
            end else if (i_pe_transmitting) begin
                protocol_activity_state <= `CTH_ACT_TX;
            end else if (i_pe_idle) begin
                protocol_activity_state <= `CTH_ACT_IDLE;
            end else begin
                protocol_activity_state <= `CTH_ACT_SYNC;
            end
        end
    end

    // ********************
    // Register port
    // ********************
    // Configuration registers written by software
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            fifo_queue_select <= 1'b0;
            irq_mask <= {`CTH_NIRQ{1'b0}};
            std_flt <= `CTH_ZERO;
            ext_flt_a <= `CTH_ZERO;
            ext_flt_b <= `CTH_ZERO;
            glb_flt <= 4'h0;
        end else if (i_wr) begin
            case (i_addr)
                `CTH_A_CFG: fifo_queue_select <= i_wdata[0];
                `CTH_A_IRQMSK: irq_mask <= i_wdata[`CTH_NIRQ-1:0];
                `CTH_A_SFLT: std_flt <= i_wdata;
                `CTH_A_EFA: ext_flt_a <= i_wdata;
                `CTH_A_EFB: ext_flt_b <= i_wdata;
                `CTH_A_GFC: glb_flt <= i_wdata[3:0];
                default: glb_flt <= glb_flt;
            endcase
        end
    end

    reg [31:0] rd_mux; // Selected read value

    // Read value selection, unmapped reads zero
    always @* begin
        case (i_addr)
            `CTH_A_CFG: rd_mux = {31'h0, fifo_queue_select};
            `CTH_A_ADDREQ: rd_mux = {24'h0, tx_request_pending};
            `CTH_A_FIFOPUT: rd_mux = {28'h0, ~put_ok, fifo_put, 1'b0};
            `CTH_A_OCCUR: rd_mux = {24'h0, tx_occurred_bits};
            `CTH_A_IRQST: rd_mux = {27'h0, irq_status};
            `CTH_A_IRQMSK: rd_mux = {27'h0, irq_mask};
            `CTH_A_PSR: rd_mux = {30'h0, protocol_activity_state};
            `CTH_A_SFLT: rd_mux = std_flt;
            `CTH_A_EFA: rd_mux = ext_flt_a;
            `CTH_A_EFB: rd_mux = ext_flt_b;
            `CTH_A_GFC: rd_mux = {28'h0, glb_flt};
            `CTH_A_EVT: rd_mux = {evt_cnt != 3'h0, 20'h0, evt_id[evt_rp]};
            default: rd_mux = `CTH_ZERO;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_rdata <= `CTH_ZERO;
        end else begin
            o_rdata <= i_rd ? rd_mux : `CTH_ZERO;
        end
    end

endmodule // cth_top

// ==== shared/cth_map.vh ====
// Register map, field positions and encodings of the CAN message handler
`ifndef CTH_MAP_VH
`define CTH_MAP_VH
// ********************
// Register offsets
// ********************
`define CTH_A_CFG 6'h00
`define CTH_A_ADDREQ 6'h04
`define CTH_A_TXMSG 6'h08
`define CTH_A_FIFOPUT 6'h0c
`define CTH_A_OCCUR 6'h10
`define CTH_A_IRQST 6'h14
`define CTH_A_IRQMSK 6'h18
`define CTH_A_PSR 6'h1c
`define CTH_A_SFLT 6'h20
`define CTH_A_EFA 6'h24
`define CTH_A_EFB 6'h28
`define CTH_A_GFC 6'h2c
`define CTH_A_EVT 6'h30
// ********************
// Field layouts
// ********************
`define CTH_F_IDX 31:29
`define CTH_F_DLC 15:12
`define CTH_F_SID 10:0
`define CTH_F_CFG 31:29
`define CTH_F_STYP 28:27
`define CTH_F_SIDA 26:16
`define CTH_F_ETYP 31:30
`define CTH_F_EID 28:0
`define CTH_F_ANFS 3:2
`define CTH_F_ANFE 1:0
`define CTH_F_EVTV 31
// ********************
// Interrupt bits
// ********************
`define CTH_I_TC 0
`define CTH_I_TFE 1
`define CTH_I_HPM 2
`define CTH_I_RXN 3
`define CTH_I_EVT 4
`define CTH_NIRQ 5
// ********************
// Encodings and reset values
// ********************
`define CTH_EC_OFF 3'h0
`define CTH_EC_F1 3'h2
`define CTH_EC_REJ 3'h3
`define CTH_EC_PF1 3'h6
`define CTH_EC_BUF 3'h7
`define CTH_FT_RANGE 2'h0
`define CTH_FT_DUAL 2'h1
`define CTH_FT_CLASSIC 2'h2
`define CTH_ANF_F0 2'h0
`define CTH_ANF_F1 2'h1
`define CTH_ACT_SYNC 2'h0
`define CTH_ACT_IDLE 2'h1
`define CTH_ACT_RX 2'h2
`define CTH_ACT_TX 2'h3
`define CTH_ZERO 32'h0
`define CTH_NDED 4
`endif

// ==== testbench/cth_top_sva.sv ====
// Checker for the transmit request and receive filter ports
`timescale 1ns/100ps
module cth_sva (
    input wire logic i_clock, // System clock
    input wire logic i_sys_rst, // Synchronous reset
    input wire logic i_rd, // Read strobe
    input wire logic [31:0] o_rdata, // Read data
    input wire logic o_pe_req, // Transmit request
    input wire logic [10:0] o_pe_id, // Request identifier
    input wire logic [3:0] o_pe_dlc, // Request length code
    input wire logic o_pe_arb_start, // Arbitration start
    input wire logic i_pe_done, // Transmission acknowledged
    input wire logic i_pe_fail, // Transmission failed
    input wire logic i_bit_tick, // Bit time pulse
    input wire logic i_ifs3_dominant, // Dominant third bit
    input wire logic i_rx_valid, // Frame received
    input wire logic o_rx_store, // Frame accepted
    input wire logic o_rx_fifo1, // Accepted into FIFO 1
    input wire logic o_rx_high_prio // Accepted as priority
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    // ********************
    // Sequences
    // ********************
    sequence busy_s;
        o_pe_req && !i_pe_done && !i_pe_fail;
    endsequence
    sequence sof_s;
        i_ifs3_dominant ##1 (i_bit_tick && o_pe_req);
    endsequence
    // ********************
    // Assertions
    // ********************
    rdata_idle_a: assert property (!i_rd |=> o_rdata == 32'h0)
        else $error("read data not zero outside read answer");
    req_hold_a: assert property (busy_s |=> o_pe_req)
        else $error("request dropped without answer");
    req_drop_a: assert property (o_pe_req && (i_pe_done || i_pe_fail)
        |=> !o_pe_req) else $error("request held after answer");
    req_gap_a: assert property ($fell(o_pe_req) |=> !o_pe_req)
        else $error("request raised before output buffer load");
    id_stable_a: assert property (busy_s |=> $stable(o_pe_id)
        && $stable(o_pe_dlc)) else $error("shift register changed");
    sof_arb_a: assert property (sof_s |-> ##[1:2] o_pe_arb_start)
        else $error("no arbitration start after dominant third bit");
    rx_cause_a: assert property (o_rx_store |-> $past(i_rx_valid))
        else $error("frame stored without reception");
    prio_store_a: assert property (o_rx_high_prio |-> o_rx_store)
        else $error("priority pulse without store");
    fifo1_store_a: assert property (o_rx_fifo1 |-> o_rx_store)
        else $error("FIFO 1 pulse without store");
endmodule // cth_sva

// ==== testbench/cth_bus_model.sv ====
// Protocol engine stand-in answering transmit requests
`timescale 1ns/100ps
module cth_bus_model (
    input wire logic i_clock, // System clock
    input wire logic i_sys_rst, // Synchronous reset
    input wire logic i_pe_req, // Request from the handler
    input wire logic [7:0] i_delay, // Cycles until the answer
    input wire logic i_fail_next, // Answer with a failure
    output logic o_done, // Acknowledged, pulse
    output logic o_fail // Lost or error, pulse
);
    logic [7:0] cnt; // Cycles the request has stood
    // Answer once per request after the chosen delay
    always @(posedge i_clock) begin
        o_done <= 1'b0;
        o_fail <= 1'b0;
        if (i_sys_rst || !i_pe_req || o_done || o_fail) begin
            cnt <= 8'h0;
        end else if (cnt == i_delay) begin
            o_fail <= i_fail_next;
            o_done <= !i_fail_next;
        end else begin
            cnt <= cnt + 8'h1;
        end
    end
endmodule // cth_bus_model

// ==== testbench/test_cth_top.sv ====
// Self-checking bench for the CAN message handler
`timescale 1ns/100ps
`include "cth_map.vh"
module test_cth_top;
    logic i_clock = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0; // Bus controls
    logic [5:0] i_addr = 0; // Address
    logic [31:0] i_wdata = 0, o_rdata, d; // Data, last read
    logic o_irq, o_pe_req, o_pe_arb_start, done, fail; // Tx status
    logic [10:0] o_pe_id; // Shift register identifier
    logic [3:0] o_pe_dlc; // Shift register length code
    logic tick = 0, ifs3 = 0, rcv = 0, xmt = 0, idle = 1; // Engine
    logic rxv = 0, rxe = 0, st, f1, hp; // Receive controls
    logic [28:0] rxid = 0; // Received identifier
    logic [7:0] dly = 8'h14; // Partner answer delay
    logic fail_next = 0; // Partner fails next attempt
    logic [10:0] sent[$]; // Identifiers acknowledged
    int mismatches = 0, tests_run = 0, k;
    always #5 i_clock = ~i_clock;
    cth_top DUT (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_irq(o_irq), .o_pe_req(o_pe_req), .o_pe_id(o_pe_id),
        .o_pe_dlc(o_pe_dlc), .o_pe_arb_start(o_pe_arb_start),
        .i_pe_done(done), .i_pe_fail(fail), .i_bit_tick(tick),
        .i_ifs3_dominant(ifs3), .i_pe_receiving(rcv),
        .i_pe_transmitting(xmt), .i_pe_idle(idle), .i_rx_valid(rxv),
        .i_rx_ext(rxe), .i_rx_id(rxid), .o_rx_store(st),
        .o_rx_fifo1(f1), .o_rx_high_prio(hp));
    cth_bus_model u_bus (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_pe_req(o_pe_req), .i_delay(dly), .i_fail_next(fail_next),
        .o_done(done), .o_fail(fail));
    // Log acknowledged IDs, drop the fail order once used
    always @(posedge i_clock) begin
        if (o_pe_req && done) sent.push_back(o_pe_id);
        if (o_pe_req && fail) fail_next <= 1'b0;
    end
    // ********************
    // Shared tasks
    // ********************
    task check(input [31:0] seen, input [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask
    task wr(input [5:0] a, input [31:0] v);
        @(posedge i_clock);
        i_wr <= 1; i_addr <= a; i_wdata <= v;
        @(posedge i_clock);
        i_wr <= 0;
    endtask
    task rd(input [5:0] a);
        @(posedge i_clock);
        i_rd <= 1; i_addr <= a;
        @(posedge i_clock);
        i_rd <= 0;
        #1 d = o_rdata;
    endtask
    // Bounded wait for the request line to reach a level
    task wait_req(input logic lvl);
        k = 0;
        while (o_pe_req !== lvl && k < 200) begin
            @(posedge i_clock);
            #1 k++;
        end
        check(o_pe_req, lvl);
    endtask
    // Send one frame and judge the filter pulses
    task rx(input e, input [28:0] id, input s, input one, input p);
        @(posedge i_clock);
        rxv <= 1; rxe <= e; rxid <= id;
        @(posedge i_clock);
        rxv <= 0; rxe <= 0;
        #1 check(st, s);
        check(f1, one);
        check(hp, p);
        rd(`CTH_A_IRQST);
        check(d[`CTH_I_HPM], p);
        wr(`CTH_A_IRQST, 32'h1f);
    endtask
    // ********************
    // Scenarios
    // ********************
    task t_dedicated;
        rd(`CTH_A_IRQST);
        check(d, 32'h0);
        wr(`CTH_A_CFG, 32'h0);
        wr(`CTH_A_IRQMSK, 32'h1f);
        wr(`CTH_A_TXMSG, 32'h00008123);
        wr(`CTH_A_ADDREQ, 32'h1);
        wait_req(1);
        check(o_pe_id, 11'h123);
        check(o_pe_dlc, 4'h8);
        @(posedge i_clock) ifs3 <= 1;
        @(posedge i_clock) begin ifs3 <= 0; tick <= 1; end
        @(posedge i_clock) tick <= 0;
        #1 k = o_pe_arb_start;
        @(posedge i_clock);
        #1 check(k | o_pe_arb_start, 1);
        wait_req(0);
        rd(`CTH_A_OCCUR);
        check(d[0], 1);
        rd(`CTH_A_IRQST);
        check(d[`CTH_I_TC], 1);
        check(o_irq, 1);
        rd(`CTH_A_EVT);
        check(d, 32'h80000123);
        wr(`CTH_A_IRQST, 32'h1f);
        repeat (2) @(posedge i_clock);
        #1 check(o_irq, 0);
        $display("dedicated buffer test done");
    endtask
    task t_order;
        sent.delete();
        fail_next <= 1;
        wr(`CTH_A_FIFOPUT, 32'h00001300);
        wr(`CTH_A_FIFOPUT, 32'h00001301);
        wait_req(1);
        wr(`CTH_A_TXMSG, 32'h20001010);
        wr(`CTH_A_ADDREQ, 32'h2);
        k = 0;
        while (sent.size() < 3 && k < 600) begin
            @(posedge i_clock);
            k++;
        end
        check(sent.size(), 3);
        check(sent[0], 11'h010);
        check(sent[1], 11'h300);
        check(sent[2], 11'h301);
        rd(`CTH_A_IRQST);
        check(d[`CTH_I_TFE], 1);
        rd(`CTH_A_ADDREQ);
        check(d[7:0], 8'h0);
        wr(`CTH_A_IRQST, 32'h1f);
        $display("FIFO order test done");
    endtask
    task t_filter;
        logic [2:0] c[5];
        c = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
        wr(`CTH_A_GFC, 32'h8);
        foreach (c[i]) begin
            wr(`CTH_A_SFLT, {c[i], 2'h2, 11'h100, 5'h0, 11'h7f0});
            rx(0, 29'h10f, 1, c[i] == 3'h2 || c[i] == 3'h6, c[i][2]);
        end
        rx(0, 29'h20f, 0, 0, 0);
        wr(`CTH_A_EFA, 32'h0);
        wr(`CTH_A_GFC, 32'h0);
        rx(1, 29'h0abcdef, 1, 0, 0);
        wr(`CTH_A_GFC, 32'h1);
        rx(1, 29'h0abcdef, 1, 1, 0);
        wr(`CTH_A_EFA, 32'h20000000);
        wr(`CTH_A_EFB, 32'h80000000);
        wr(`CTH_A_GFC, 32'h2);
        rx(1, 29'h1234567, 1, 0, 0);
        wr(`CTH_A_IRQMSK, 32'h0);
        wr(`CTH_A_SFLT, {3'h4, 2'h2, 11'h0, 5'h0, 11'h0});
        @(posedge i_clock) rxv <= 1;
        @(posedge i_clock) rxv <= 0;
        repeat (3) @(posedge i_clock);
        #1 check(o_irq, 0);
        wr(`CTH_A_IRQMSK, 32'h1 << `CTH_I_HPM);
        repeat (2) @(posedge i_clock);
        #1 check(o_irq, 1);
        wr(`CTH_A_IRQST, 32'h1f);
        $display("filter test done");
    endtask
    task t_activity;
        @(posedge i_clock) begin rcv <= 1; idle <= 0; end
        rd(`CTH_A_PSR);
        check(d[1:0], `CTH_ACT_RX);
        @(posedge i_clock) begin rcv <= 0; idle <= 1; end
        $display("activity test done");
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ********************
    // Main sequence and watchdog
    // ********************
    initial begin
        repeat (8) @(posedge i_clock);
        i_sys_rst <= 0;
        t_dedicated;
        t_order;
        t_filter;
        t_activity;
        summarize;
    end
    initial begin
        #60000;
        mismatches++;
        summarize;
    end
endmodule // test_cth_top
bind cth_top cth_sva u_sva (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_pe_req(o_pe_req),
    .o_pe_id(o_pe_id), .o_pe_dlc(o_pe_dlc),
    .o_pe_arb_start(o_pe_arb_start), .i_pe_done(i_pe_done),
    .i_pe_fail(i_pe_fail), .i_bit_tick(i_bit_tick),
    .i_ifs3_dominant(i_ifs3_dominant), .i_rx_valid(i_rx_valid),
    .o_rx_store(o_rx_store), .o_rx_fifo1(o_rx_fifo1),
    .o_rx_high_prio(o_rx_high_prio));
